// ==== core/cisp_pkg.sv ====
package cisp_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] IDX_STATUS  = 8'h00;
  localparam logic [7:0] IDX_CTRL    = 8'h02;
  localparam logic [7:0] RD_UNDEF    = 8'hff;
  localparam logic [6:0] CTRL_RST    = 7'h0c; // Control bits 6..0 after reset
  localparam logic       CTRL_B7_RD  = 1'b1;  // Register-reset bit always reads 1
  localparam logic       SUPSEL_RST  = 1'b0;  // Adapter input has precedence
  localparam logic       STATEN_RST  = 1'b1;
  localparam int         KICK_BIT    = 7;
  localparam int         SUPSEL_BIT  = 3;
  localparam int         STATEN_BIT  = 3;
  localparam int         CRST_BIT    = 7;
  localparam int         EV_N        = 7;
  localparam int         CODE_W      = 3;

  // ****************************************
  // Bus
  // ****************************************
  localparam logic [6:0] SLAVE_ADDR  = 7'h6b;
  localparam int         STD_KBPS    = 100;
  localparam int         FAST_KBPS   = 400;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // ****************************************
  // State and fault codes
  // ****************************************
  localparam logic [2:0] ST_NO_SRC   = 3'h0;
  localparam logic [2:0] ST_IN_RDY   = 3'h1;
  localparam logic [2:0] ST_USB_RDY  = 3'h2;
  localparam logic [2:0] ST_CHG_IN   = 3'h3;
  localparam logic [2:0] ST_CHG_USB  = 3'h4;
  localparam logic [2:0] ST_DONE     = 3'h5;
  localparam logic [2:0] ST_FAULT    = 3'h7;
  localparam logic [2:0] FLT_NONE    = 3'h0;
  localparam logic [2:0] FLT_TSHUT   = 3'h1;
  localparam logic [2:0] FLT_BATTEMP = 3'h2;
  localparam logic [2:0] FLT_WDOG    = 3'h3;
  localparam logic [2:0] FLT_SAFETY  = 3'h4;
  localparam logic [2:0] FLT_IN_SUP  = 3'h5;
  localparam logic [2:0] FLT_USB_SUP = 3'h6;
  localparam logic [2:0] FLT_BATT    = 3'h7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_MHZ     = 25;
  localparam int          PULSE_US    = 128;
  localparam int          PULSE_CYC_I = PULSE_US * CLK_MHZ;
  localparam logic [11:0] PULSE_CYC   = 12'(PULSE_CYC_I);

  typedef enum logic [2:0] {L_IDLE, L_RX, L_ACK, L_TX, L_RACK} cisp_lst_t;
  typedef enum logic [1:0] {K_ADDR, K_IDX, K_DATA} cisp_kind_t;
endpackage : cisp_pkg

// ==== core/cisp_top.sv ====
`timescale 1ns/1ns
// Functional notes
// [RULE1] Status pin pulled low while charging when the status enable bit is 1.
// [RULE2] Status pin released when charge is done, disabled, or otherwise idle.
// [RULE3] Each qualifying event gives one 128 us low pulse on the status pin; an event during a running pulse is merged into it instead.
// [RULE4] Event pulses appear regardless of the status enable bit.
// [RULE5] Interrupt pin behaves exactly like the status pin.
// [RULE6] Plug/unplug, timer, watchdog, sleep, temperature, battery, thermal events pulse.
// [RULE7] Default mode with good battery forces high impedance mode.
// [RULE8] Host mode ignores the good battery comparison.
// [RULE9] Slave only; 100 and 400 kbit/s rates use the same protocol.
// [RULE10] Seven-bit addressing; answers only address 6Bh.
// [RULE11] START is SDA falling with SCL high, detected at any time.
// [RULE12] Transmitter keeps SDA stable while SCL is high.
// [RULE13] Acknowledge a matching address by holding SDA low in ninth clock.
// [RULE14] Every byte is followed by an acknowledge from the receiver.
// [RULE15] STOP is SDA rising with SCL high; slave releases and idles.
// [RULE16] Master sends STOP after an aborted transfer to reset the slave.
// [RULE17] Reads of undefined indexes return FFh.
// [RULE18] Writing 1 to bit 7 of index 0 kicks the watchdog; reads 0.
// [RULE19] Bits 6..4 of index 0 report the device state code.
// [RULE20] Bit 3 of index 0 picks supply precedence: 0 adapter, 1 USB.
// [RULE21] Bits 2..0 of index 0 report the fault code.
// [RULE22] Fault code latched until read and cleared; first fault retained.
// [RULE23] State field tracks device state without waiting for a read.
// [RULE24] Status enable is bit 3 of index 2, reset value 1.
// [RULE25] Direction bit 0 means master write, 1 means master read.
// [RULE26] First written byte selects index; later bytes write it; reads use it.
module cisp_top (
  input  wire logic                          CLK,
  input  wire logic                          RST_B,
  input  wire logic                          LINK_CLK,
  input  wire logic                          SCL_IN,
  input  wire logic                          SDA_IN,
  output logic                               SDA_OUT,
  output logic                               SDA_OE,
  input  wire logic [cisp_pkg::CODE_W-1:0]   CHG_STATE,
  input  wire logic [cisp_pkg::CODE_W-1:0]   FAULT_IN,
  input  wire logic [cisp_pkg::EV_N-1:0]     EVENT_IN,
  input  wire logic                          HOST_MODE,
  input  wire logic                          BAT_GOOD,
  output logic                               STAT_OUT,
  output logic                               STAT_OE,
  output logic                               INT_OUT,
  output logic                               INT_OE,
  output logic                               HIZ_FORCE,
  output logic                               SUPPLY_SEL,
  output logic                               WDOG_KICK
);
  import cisp_pkg::*;

  // ****************************************
  // Link domain declarations
  // ****************************************
  logic        lrst_s1;
  logic        lrst_b;
  logic [2:0]  scl_s;
  logic [2:0]  sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        byte_end;
  logic        tx_load;
  cisp_lst_t   st;
  cisp_kind_t  kind;
  logic [3:0]  cnt;
  logic [7:0]  sh;
  logic [7:0]  tx;
  logic [7:0]  idx;
  logic [7:0]  rdata;
  logic        rw;
  logic        mack;
  logic        sup_sel;
  logic [6:0]  ctrl;
  logic        kick_tgl;
  logic        frd_tgl;
  logic        ack_tgl;
  logic [1:0]  lreq;
  logic [5:0]  snap;

  // ****************************************
  // Core domain declarations
  // ****************************************
  logic [1:0]  ss_sup;
  logic [1:0]  ss_en;
  logic [2:0]  ss_kick;
  logic [2:0]  ss_frd;
  logic [1:0]  ss_ack;
  logic [1:0]  bat_s;
  logic        req_tgl;
  logic [5:0]  hold;
  logic [2:0]  flt;
  logic        rd_seen;
  logic        ev_q;
  logic [11:0] pulse_cnt;
  logic        charging;
  logic        kick_ev;
  logic        frd_ev;

  // ****************************************
  // Link sampling
  // ****************************************
  // Reset is brought into the link clock before use
  always_ff @(posedge LINK_CLK) begin
    lrst_s1 <= RST_B;
    lrst_b  <= lrst_s1;
  end

  // Both bus lines oversampled; rate agnostic so 100k and 400k look alike
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_b) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], SCL_IN}; // RULE9
      sda_s <= {sda_s[1:0], SDA_IN};
    end
  end

  // Edges and bus conditions, only from settled samples
  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_c  = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1]; // RULE11
  assign stop_c   = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1]; // RULE15
  assign byte_end = (st == L_RX) & scl_fall & (cnt == BYTE_BITS);
  assign tx_load  = scl_fall & (((st == L_ACK) & (kind == K_ADDR) & rw) |
                                ((st == L_RACK) & mack));

  // Read data for the selected index
  always_comb begin
    if (idx == IDX_STATUS) begin
      rdata = {1'b0, snap[5:3], sup_sel, snap[2:0]}; // RULE18 RULE19 RULE21
    end else if (idx == IDX_CTRL) begin
      rdata = {CTRL_B7_RD, ctrl};
    end else begin
      rdata = RD_UNDEF; // RULE17
    end
  end

  // ****************************************
  // Slave protocol engine
  // ****************************************
  // Acks and data are driven after SCL falls, so SDA never moves in a high phase
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_b) begin
      st     <= L_IDLE;
      kind   <= K_ADDR;
      cnt    <= 4'h0;
      sh     <= 8'h00;
      tx     <= 8'h00;
      idx    <= 8'h00;
      rw     <= 1'b0;
      mack   <= 1'b0;
      SDA_OE <= 1'b0;
    end else if (start_c) begin
      st     <= L_RX; // RULE11
      kind   <= K_ADDR;
      cnt    <= 4'h0;
      SDA_OE <= 1'b0;
    end else if (stop_c) begin
      st     <= L_IDLE; // RULE15 RULE16
      SDA_OE <= 1'b0;
    end else begin
      case (st)
        L_RX: begin
          if (scl_rise) begin
            sh  <= {sh[6:0], sda_s[1]}; // RULE12
            cnt <= cnt + 4'h1;
          end else if (byte_end) begin
            cnt <= 4'h0;
            if (kind == K_ADDR && sh[7:1] != SLAVE_ADDR) begin
              st <= L_IDLE; // RULE10 RULE13
            end else begin
              st     <= L_ACK; // RULE13 RULE14
              SDA_OE <= 1'b1;
            end
            if (kind == K_ADDR) begin
              rw <= sh[0]; // RULE25
            end
            if (kind == K_IDX) begin
              idx <= sh; // RULE26
            end
          end
        end
        L_ACK: begin
          if (tx_load) begin
            st     <= L_TX;
            tx     <= rdata;
            SDA_OE <= ~rdata[7];
          end else if (scl_fall) begin
            st     <= L_RX;
            SDA_OE <= 1'b0;
            kind   <= (kind == K_ADDR) ? K_IDX : K_DATA; // RULE26
          end
        end
        L_TX: begin
          if (scl_fall && cnt == LAST_TX_BIT) begin
            st     <= L_RACK;
            cnt    <= 4'h0;
            SDA_OE <= 1'b0;
          end else if (scl_fall) begin
            cnt    <= cnt + 4'h1;
            tx     <= {tx[6:0], 1'b0};
            SDA_OE <= ~tx[6];
          end
        end
        L_RACK: begin
          // Master ack continues the read; a nack returns to idle at the next SCL fall
          if (scl_rise) begin
            mack <= ~sda_s[1]; // RULE14
          end else if (tx_load) begin
            st     <= L_TX;
            tx     <= rdata;
            SDA_OE <= ~rdata[7];
          end else if (scl_fall) begin
            st <= L_IDLE;
          end
        end
        default: st <= L_IDLE;
      endcase
    end
  end

  // Open drain data line: the level driven is always low
  always_ff @(posedge LINK_CLK) begin
    SDA_OUT <= 1'b0;
  end

  // ****************************************
  // Register writes and read notices
  // ****************************************
  // Kick and fault-read cross as toggles, the writable bits as levels
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_b) begin
      sup_sel  <= SUPSEL_RST;
      ctrl     <= CTRL_RST;
      kick_tgl <= 1'b0;
      frd_tgl  <= 1'b0;
    end else begin
      if (byte_end && kind == K_DATA && idx == IDX_STATUS) begin
        sup_sel <= sh[SUPSEL_BIT]; // RULE20
        if (sh[KICK_BIT]) begin
          kick_tgl <= ~kick_tgl; // RULE18
        end
      end
      if (byte_end && kind == K_DATA && idx == IDX_CTRL) begin
        if (sh[CRST_BIT]) begin
          ctrl    <= CTRL_RST;
          sup_sel <= SUPSEL_RST;
        end else begin
          ctrl <= sh[6:0]; // RULE24
        end
      end
      if (tx_load && idx == IDX_STATUS) begin
        frd_tgl <= ~frd_tgl;
      end
    end
  end

  // Status word arrives by handshake; hold is stable while req and ack differ
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_b) begin
      lreq    <= 2'h0;
      ack_tgl <= 1'b0;
      snap    <= 6'h00;
    end else begin
      lreq <= {lreq[0], req_tgl};
      if (lreq[1] != ack_tgl) begin
        snap    <= hold; // RULE23
        ack_tgl <= lreq[1];
      end
    end
  end

  // ****************************************
  // Core domain crossings
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ss_sup  <= {2{SUPSEL_RST}};
      ss_en   <= {2{STATEN_RST}};
      ss_kick <= 3'h0;
      ss_frd  <= 3'h0;
      ss_ack  <= 2'h0;
      bat_s   <= 2'h0;
    end else begin
      ss_sup  <= {ss_sup[0], sup_sel};
      ss_en   <= {ss_en[0], ctrl[STATEN_BIT]};
      ss_kick <= {ss_kick[1:0], kick_tgl};
      ss_frd  <= {ss_frd[1:0], frd_tgl};
      ss_ack  <= {ss_ack[0], ack_tgl};
      bat_s   <= {bat_s[0], BAT_GOOD};
    end
  end

  assign kick_ev  = ss_kick[2] ^ ss_kick[1];
  assign frd_ev   = ss_frd[2] ^ ss_frd[1];
  assign charging = (CHG_STATE == ST_CHG_IN) | (CHG_STATE == ST_CHG_USB);

  // Publish state and fault whenever the link has taken the previous word
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      req_tgl <= 1'b0;
      hold    <= {ST_NO_SRC, FLT_NONE};
    end else if (ss_ack[1] == req_tgl) begin
      hold    <= {CHG_STATE, flt}; // RULE19 RULE23
      req_tgl <= ~req_tgl;
    end
  end

  // ****************************************
  // Fault latch
  // ****************************************
  // A fault still present at read time stays; it clears once gone after a read
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      flt     <= FLT_NONE;
      rd_seen <= 1'b0;
    end else if (flt == FLT_NONE) begin
      flt     <= FAULT_IN; // RULE22
      rd_seen <= 1'b0;
    end else if (rd_seen && FAULT_IN == FLT_NONE) begin
      flt     <= FLT_NONE; // RULE21
      rd_seen <= 1'b0;
    end else if (frd_ev) begin
      rd_seen <= 1'b1;
    end
  end

  // ****************************************
  // Status and interrupt pins
  // ****************************************
  // Events during a running pulse are merged into it
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ev_q      <= 1'b0;
      pulse_cnt <= 12'h000;
    end else begin
      ev_q <= |EVENT_IN; // RULE6
      if (ev_q && pulse_cnt == 12'h000) begin
        pulse_cnt <= PULSE_CYC; // RULE3
      end else if (pulse_cnt != 12'h000) begin
        pulse_cnt <= pulse_cnt - 12'h001;
      end
    end
  end

  // Pulse ignores the enable bit; the enable gates only the charge level
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      STAT_OE <= 1'b0;
      INT_OE  <= 1'b0;
    end else begin
      STAT_OE <= (pulse_cnt != 12'h000) | (charging & ss_en[1]); // RULE1 RULE2 RULE4
      INT_OE  <= (pulse_cnt != 12'h000) | (charging & ss_en[1]); // RULE5
    end
  end

  // Level outputs toward the charger core
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      STAT_OUT   <= 1'b0;
      INT_OUT    <= 1'b0;
      HIZ_FORCE  <= 1'b0;
      SUPPLY_SEL <= SUPSEL_RST;
      WDOG_KICK  <= 1'b0;
    end else begin
      STAT_OUT   <= 1'b0;
      INT_OUT    <= 1'b0;
      HIZ_FORCE  <= ~HOST_MODE & bat_s[1]; // RULE7 RULE8
      SUPPLY_SEL <= ss_sup[1]; // RULE20
      WDOG_KICK  <= kick_ev; // RULE18
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_addr_hit;
    byte_end && kind == K_ADDR && sh[7:1] == SLAVE_ADDR;
  endsequence
  sequence s_addr_miss;
    byte_end && kind == K_ADDR && sh[7:1] != SLAVE_ADDR && !start_c && !stop_c;
  endsequence
  sequence s_ev_idle;
    ev_q && pulse_cnt == 12'h000;
  endsequence

  a_addr_ack: assert property (@(posedge LINK_CLK) disable iff (!lrst_b) // RULE13
    s_addr_hit and !start_c and !stop_c |=> SDA_OE && st == L_ACK)
    else $error("matching address not acknowledged");
  a_addr_nack: assert property (@(posedge LINK_CLK) disable iff (!lrst_b) // RULE10
    s_addr_miss |=> !SDA_OE && st == L_IDLE)
    else $error("foreign address acknowledged");
  a_stop_idle: assert property (@(posedge LINK_CLK) disable iff (!lrst_b) // RULE15
    stop_c && !start_c |=> st == L_IDLE && !SDA_OE)
    else $error("stop did not release bus");
  a_start_rx: assert property (@(posedge LINK_CLK) disable iff (!lrst_b) // RULE11
    start_c |=> st == L_RX && cnt == 4'h0 && kind == K_ADDR)
    else $error("start not detected");
  a_undef_ff: assert property (@(posedge LINK_CLK) disable iff (!lrst_b) // RULE17
    tx_load && idx != IDX_STATUS && idx != IDX_CTRL && !start_c && !stop_c
    |=> tx == RD_UNDEF)
    else $error("undefined index not read as ff");
  a_pulse_load: assert property (@(posedge CLK) disable iff (!RST_B) // RULE3
    s_ev_idle |=> pulse_cnt == PULSE_CYC ##1 STAT_OE)
    else $error("event pulse length wrong");
  a_pulse_run: assert property (@(posedge CLK) disable iff (!RST_B) // RULE4
    pulse_cnt != 12'h000 |=> STAT_OE && pulse_cnt == $past(pulse_cnt) - 12'h001)
    else $error("pulse not driven or not counting");
  a_event_pin: assert property (@(posedge CLK) disable iff (!RST_B) // RULE6
    |EVENT_IN |-> ##[1:3] STAT_OE)
    else $error("event gave no pulse");
  a_chg_low: assert property (@(posedge CLK) disable iff (!RST_B) // RULE1
    charging && ss_en[1] |=> STAT_OE)
    else $error("charging not shown");
  a_idle_hiz: assert property (@(posedge CLK) disable iff (!RST_B) // RULE2
    !charging && pulse_cnt == 12'h000 |=> !STAT_OE)
    else $error("status pin driven while idle");
  a_int_mirror: assert property (@(posedge CLK) disable iff (!RST_B) // RULE5
    INT_OE == STAT_OE)
    else $error("interrupt pin differs from status pin");
  a_hiz_force: assert property (@(posedge CLK) disable iff (!RST_B) // RULE7
    !HOST_MODE && bat_s[1] |=> HIZ_FORCE)
    else $error("good battery did not force high impedance");
  a_hiz_host: assert property (@(posedge CLK) disable iff (!RST_B) // RULE8
    HOST_MODE |=> !HIZ_FORCE)
    else $error("host mode forced high impedance");
  a_fault_hold: assert property (@(posedge CLK) disable iff (!RST_B) // RULE22
    flt != FLT_NONE && !(rd_seen && FAULT_IN == FLT_NONE) |=> flt == $past(flt))
    else $error("latched fault changed");
endmodule : cisp_top

// ==== dv/cisp_host.sv ====
`timescale 1ns/1ns
// ****************************************
// Host bus master model
// ****************************************
module cisp_host (
  input  wire logic       lclk,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_pull,
  output logic            got_v,
  output logic [7:0]      got
);
  import cisp_pkg::*;
  int half = 104; // Link cycles per clock phase, near 400 kbit/s

  // Idle bus: both lines left to the pull-ups
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    got_v = 1'b0;
    got = 8'h00;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge lclk);
  endtask : wt

  // Data falls while the clock is high
  task automatic start();
    wt(half);
    sda_pull <= 1'b1;
    wt(half);
    scl <= 1'b0;
  endtask : start

  // Data rises while the clock is high; also recovers an aborted transfer
  task automatic stop();
    wt(2);
    sda_pull <= 1'b1;
    wt(half);
    scl <= 1'b1;
    wt(half);
    sda_pull <= 1'b0;
    wt(half);
  endtask : stop

  // Data moves two link cycles after the fall, never while the clock is high
  task automatic bitx(input logic b, output logic s);
    wt(2);
    sda_pull <= !b;
    wt(half);
    scl <= 1'b1;
    wt(half / 2);
    s = sda;
    wt(half - half / 2);
    scl <= 1'b0;
  endtask : bitx

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic r);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, r);
  endtask : xfer

  // Index byte first, then an optional data byte
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic has_d,
                    input logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic       r;
    start();
    xfer({a, 1'b0}, 1'b1, q, ack);
    xfer(idx, 1'b1, q, r);
    if (has_d) xfer(d, 1'b1, q, r);
    stop();
  endtask : wr

  // One byte at the current index, refused by the master, then stop
  task automatic rd(output logic ack);
    logic [7:0] q;
    logic       r;
    start();
    xfer({SLAVE_ADDR, 1'b1}, 1'b1, q, ack);
    xfer(8'hff, 1'b1, q, r);
    stop();
    got <= q;
    got_v <= 1'b1;
    wt(1);
    got_v <= 1'b0;
  endtask : rd
endmodule : cisp_host

// ==== dv/charger_i2c_status_port_test.sv ====
`timescale 1ns/1ns
module charger_i2c_status_port_test;
  import cisp_pkg::*;
  logic       clk, rst_b, lclk, scl, sda, sda_pull, sda_oe, got_v, ack;
  logic       stat_oe, int_oe, hiz_force, supply_sel, wdog_kick, host_mode, bat_good;
  logic       sda_out, stat_out, int_out;
  logic [2:0] chg_state, fault_in;
  logic [6:0] event_in;
  logic [7:0] got, r;
  logic [2:0] sts [7] = '{ST_NO_SRC, ST_IN_RDY, ST_USB_RDY, ST_CHG_IN, ST_CHG_USB,
                          ST_DONE, ST_FAULT};
  logic [7:0] exp_q [$];
  int         len_q [$];
  int         n_errors, checks_done, kicks, plen;

  assign sda = !(sda_pull | sda_oe); // Pull-up wins when nobody drives

  cisp_host h (.lclk(lclk), .sda(sda), .scl(scl), .sda_pull(sda_pull), .got_v(got_v),
               .got(got));
  cisp_top uut (.CLK(clk), .RST_B(rst_b), .LINK_CLK(lclk), .SCL_IN(scl), .SDA_IN(sda),
                .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CHG_STATE(chg_state),
                .FAULT_IN(fault_in), .EVENT_IN(event_in), .HOST_MODE(host_mode),
                .BAT_GOOD(bat_good), .STAT_OUT(stat_out), .STAT_OE(stat_oe),
                .INT_OUT(int_out), .INT_OE(int_oe),
                .HIZ_FORCE(hiz_force), .SUPPLY_SEL(supply_sel), .WDOG_KICK(wdog_kick));

  // Clocks unrelated in phase
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #5;
    forever #6 lclk = ~lclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    h.rd(ack);
    chk(ack, 1'b0, "read ack");
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic has_d, input logic [7:0] d);
    h.wr(SLAVE_ADDR, idx, has_d, d, ack);
    chk(ack, 1'b0, "write ack");
  endtask : wr

  // Bounded wait on the status pin; a hang ends the run
  task automatic wait_oe(input logic v);
    int i;
    for (i = 0; i < 4000 && stat_oe !== v; i++) @(posedge clk);
    if (i == 4000) begin
      chk(stat_oe, v, "pin wait");
      wrap_up();
    end
  endtask : wait_oe

  // Read bytes against the oldest note
  always @(posedge lclk) begin
    if (got_v === 1'b1) chk(got, exp_q.pop_front(), "read data");
  end

  // Pin mirror, pulse length and kick count
  always @(posedge clk) begin
    chk(int_oe, stat_oe, "int pin");
    // Open-drain levels are only meaningful once reset has loaded them
    if (rst_b === 1'b1) chk({sda_out, stat_out, int_out}, 3'h0, "pin levels");
    if (wdog_kick === 1'b1) kicks++;
    if (stat_oe === 1'b1) plen++;
    else begin
      if (plen > 0 && len_q.size() > 0) chk(plen, len_q.pop_front(), "pulse");
      plen = 0;
    end
  end

  // Hang guard
  initial begin
    #3900000;
    chk(1'b0, 1'b1, "run timeout");
    wrap_up();
  end

  initial begin
    rst_b = 1'b0;
    chg_state = ST_NO_SRC;
    fault_in = FLT_NONE;
    event_in = 7'h00;
    host_mode = 1'b0;
    bat_good = 1'b0;
    // Four edges so the link side sees the reset as well
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (12) @(posedge clk);
    r = $urandom(32'h8722);
    // Near 200 kbit/s, then fast rate for the rest
    h.half = 208;
    wr(IDX_CTRL, 1'b0, 8'h00);
    rd(8'h8c);
    h.half = 104;
    h.wr(SLAVE_ADDR ^ 7'h01, IDX_STATUS, 1'b1, 8'h88, ack);
    chk(ack, 1'b1, "foreign address");
    chk(kicks, 0, "foreign write");
    wr(8'h01, 1'b0, 8'h00);
    rd(RD_UNDEF);
    wr(8'hc3, 1'b0, 8'h00);
    rd(RD_UNDEF);
    // Random control bits with the status enable cleared
    r = $urandom & 8'h77;
    wr(IDX_CTRL, 1'b1, r);
    rd(r | 8'h80);
    wr(IDX_STATUS, 1'b1, 8'h88);
    repeat (10) @(posedge clk);
    chk(kicks, 1, "kick");
    chk(supply_sel, 1'b1, "supply select");
    // Every state and fault code; a later fault must not replace the first
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) chg_state <= sts[i];
      fault_in <= 3'(i + 1);
      repeat (3) @(posedge clk);
      fault_in <= 3'(i + 2);
      repeat (3) @(posedge clk);
      fault_in <= FLT_NONE;
      repeat (30) @(posedge clk);
      rd({1'b0, sts[i], 1'b1, 3'(i + 1)});
    end
    // One pulse per event kind with the enable off; a second event is absorbed
    for (int k = 0; k < EV_N; k++) begin
      len_q.push_back(PULSE_CYC_I);
      @(posedge clk) event_in <= 7'(1 << k);
      @(posedge clk) event_in <= 7'h00;
      wait_oe(1'b1);
      if (k == 0) begin
        repeat (50) @(posedge clk);
        event_in <= 7'h7f;
        @(posedge clk) event_in <= 7'h00;
      end
      wait_oe(1'b0);
      repeat (3) @(posedge clk);
    end
    chk(len_q.size(), 0, "pulse count");
    chg_state <= ST_CHG_USB;
    repeat (8) @(posedge clk);
    chk(stat_oe, 1'b0, "charge hidden");
    wr(IDX_CTRL, 1'b1, 8'h0c);
    repeat (8) @(posedge clk);
    chk(stat_oe, 1'b1, "charge shown");
    chg_state <= ST_DONE;
    repeat (4) @(posedge clk);
    chk(stat_oe, 1'b0, "charge done");
    wr(IDX_CTRL, 1'b1, 8'h80);
    rd(8'h8c);
    chk(supply_sel, SUPSEL_RST, "select reset");
    // Mode and battery level in random order
    for (int j = 0; j < 6; j++) begin
      @(posedge clk) {host_mode, bat_good} <= 2'($urandom);
      repeat (8) @(posedge clk);
      chk(hiz_force, !host_mode & bat_good, "high impedance");
    end
    chk(exp_q.size(), 0, "reads left");
    wrap_up();
  end
endmodule : charger_i2c_status_port_test
